// File: design/vdo_fifo.sv
`timescale 1ns/1ps
`include "vdo_params.svh"
// Pixel FIFO; push when full and pop when empty are dropped
module vdo_fifo (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   vdo_fifo_if.mem f
);
   localparam int DEPTH = 1 << `VDO_FIFO_AW;
   logic [`VDO_PIX_W-1:0] mem [DEPTH];
   logic [`VDO_FIFO_AW-1:0] wr_ptr_ff;
   logic [`VDO_FIFO_AW-1:0] rd_ptr_ff;
   logic [`VDO_FIFO_AW:0] level_ff;
   logic do_push;
   logic do_pop;
   // ----------------------------------------
   // Pointers and level
   // ----------------------------------------
   assign do_push = f.push && (level_ff != DEPTH[`VDO_FIFO_AW:0]);
   assign do_pop = f.pop && (level_ff != '0);
   assign f.level = level_ff;
   assign f.full = level_ff == DEPTH[`VDO_FIFO_AW:0];
   assign f.empty = level_ff == '0;
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in || f.flush) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         level_ff <= '0;
      end else begin
         wr_ptr_ff <= wr_ptr_ff + {{(`VDO_FIFO_AW-1){1'b0}}, do_push};
         rd_ptr_ff <= rd_ptr_ff + {{(`VDO_FIFO_AW-1){1'b0}}, do_pop};
         level_ff <= level_ff + {{`VDO_FIFO_AW{1'b0}}, do_push}
            - {{`VDO_FIFO_AW{1'b0}}, do_pop};
      end
   end
   // Storage has no reset, contents are only seen after a push
   always_ff @(posedge mclk_in) begin
      if (do_push) begin
         mem[wr_ptr_ff] <= f.wdata;
      end
   end
   // Read word stays until the next pop
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         f.rdata <= '0;
      end else if (do_pop) begin
         f.rdata <= mem[rd_ptr_ff];
      end
   end
endmodule

// File: design/vdo_output_port.sv
`timescale 1ns/1ps
`include "vdo_params.svh"
// How it works
// - Rising source switch restarts line and field timing for the new source.
// - Address select low gives 88h no filter; high gives 8Ah with filter.
// - Active-low reset puts every counter, control register and output in reset state, but not the FIFO storage.
// - Line-locked: horizontal reference high from line start for 720 samples.
// - Async modes: horizontal reset is one pixel clock, after last pixel.
// - Horizontal output polarity follows the sync polarity select bit.
// - Async modes: vertical reset one pixel clock, active low, after horizontal reset.
// - Line-locked: vertical reference marks the start of the next field.
// - Simple async: valid rises at almost-full margin, falls when empty.
// - Controlled async: valid paces a burst of margin reads for the reader.
// - Basic async: valid shows any entry, pixels and control codes alike.
// - Data valid polarity follows the valid polarity select bit.
// - Tristate control high floats all twenty pixel port bits.
// - Field output active during even fields, level set by field polarity.
module vdo_output_port #(
   parameter logic [9:0] H_TOTAL = `VDO_H_TOTAL,
   parameter logic [8:0] V_LINES = `VDO_V_LINES
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   output logic irq_out,
   input wire logic pixel_clock_in,
   input wire logic [19:0] core_pixel_in,
   input wire logic source_switch_in,
   input wire logic address_lsb_select_in,
   input wire logic fifo_read_in,
   input wire logic output_tristate_in,
   output logic [19:0] pixel_port_bits_out,
   output logic [19:0] pixel_port_oe_n_out,
   output logic h_timing_out,
   output logic v_timing_out,
   output logic data_valid_flag_out,
   output logic field_parity_out,
   output logic reacquire_out,
   output logic [7:0] serial_addr_out,
   output logic serial_filter_en_out
);
   import vdo_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [4:0] pin_q;
   logic pclk_q;
   logic rd_q;
   logic iso_q;
   logic tri_q;
   logic address_lsb_select_q;
   logic pclk_d_ff;
   logic iso_d_ff;
   logic pix_rise;
   logic iso_rise;
   logic [4:0] ctrl_ff;
   logic [4:0] margin_ff;
   logic [2:0] status_ff;
   logic [2:0] mask_ff;
   logic [2:0] events;
   vdo_mode_t mode;
   logic is_async;
   logic [9:0] h_cnt_ff;
   logic [8:0] v_cnt_ff;
   logic [9:0] nxt_h_cnt;
   logic [8:0] nxt_v_cnt;
   logic h_last;
   logic v_last;
   logic field_even_ff;
   logic h_act_ff;
   logic v_act_ff;
   logic [19:0] pix_ff;
   logic [19:0] oe_n_ff;
   logic reacq_ff;
   vdo_dv_state_t dv_state_ff;
   vdo_dv_state_t nxt_dv_state;
   logic [4:0] burst_ff;
   logic [4:0] nxt_burst;
   logic dv_on;
   logic [31:0] nxt_rdata;
   vdo_fifo_if f ();

   // Pixel is inside the 720-sample active part of a line
   function automatic logic in_active(input logic [9:0] h);
      in_active = h < `VDO_H_ACTIVE;
   endfunction

   // ----------------------------------------
   // Pin synchronisers and edge finders
   // ----------------------------------------
   vdo_sync #(.W(5)) u_sync (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .d_in({pixel_clock_in, fifo_read_in, source_switch_in,
         output_tristate_in, address_lsb_select_in}),
      .q_out(pin_q)
   );
   assign {pclk_q, rd_q, iso_q, tri_q, address_lsb_select_q} = pin_q;

   // Edge memory sits after the synchroniser, never on its first stage
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         pclk_d_ff <= 1'b0;
         iso_d_ff <= 1'b0;
      end else begin
         pclk_d_ff <= pclk_q;
         iso_d_ff <= iso_q;
      end
   end
   assign pix_rise = pclk_q && !pclk_d_ff;
   assign iso_rise = iso_q && !iso_d_ff;

   // ----------------------------------------
   // Line and field timing
   // ----------------------------------------
   assign mode = vdo_mode_t'(ctrl_ff[`VDO_CTRL_MODE_LSB +: 2]);
   assign is_async = mode != VDO_LINE_LOCKED;
   assign h_last = h_cnt_ff == H_TOTAL - 10'd1;
   assign v_last = v_cnt_ff == V_LINES - 9'd1;

   // Counters advance on each pixel clock rise
   always_comb begin
      nxt_h_cnt = h_cnt_ff;
      nxt_v_cnt = v_cnt_ff;
      if (iso_rise) begin
         nxt_h_cnt = '0;
         nxt_v_cnt = '0;
      end else if (pix_rise) begin
         nxt_h_cnt = h_last ? 10'd0 : h_cnt_ff + 10'd1;
         if (h_last) begin
            nxt_v_cnt = v_last ? 9'd0 : v_cnt_ff + 9'd1;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         h_cnt_ff <= '0;
         v_cnt_ff <= '0;
      end else begin
         h_cnt_ff <= nxt_h_cnt;
         v_cnt_ff <= nxt_v_cnt;
      end
   end

   // Field parity flips at each field wrap; a switch restarts on odd
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in || iso_rise) begin
         field_even_ff <= 1'b0;
      end else if (pix_rise && h_last && v_last) begin
         field_even_ff <= !field_even_ff;
      end
   end

   // Strobes decoded from the next count so they align with it
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         h_act_ff <= 1'b0;
         v_act_ff <= 1'b0;
      end else if (is_async) begin
         h_act_ff <= nxt_h_cnt == `VDO_H_ACTIVE;
         v_act_ff <= (nxt_v_cnt == V_LINES - 9'd1)
            && (nxt_h_cnt == `VDO_H_ACTIVE + 10'd1);
      end else begin
         h_act_ff <= in_active(nxt_h_cnt);
         v_act_ff <= (nxt_h_cnt == '0) && (nxt_v_cnt == '0);
      end
   end

   // Async vertical reset is always active low, independent of polarity
   assign h_timing_out = h_act_ff ^ !ctrl_ff[`VDO_CTRL_SPOL];
   assign v_timing_out = is_async ? !v_act_ff : v_act_ff;
   assign field_parity_out = field_even_ff
      ^ !ctrl_ff[`VDO_CTRL_FPOL];

   // ----------------------------------------
   // FIFO feed and drain
   // ----------------------------------------
   vdo_fifo u_fifo (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .f(f)
   );

   // Basic mode also queues a control code after the last pixel
   assign f.push = is_async && pix_rise && (in_active(h_cnt_ff)
      || (mode == VDO_BASIC_ASYNC && h_cnt_ff == `VDO_H_ACTIVE));
   assign f.wdata = in_active(h_cnt_ff) ? core_pixel_in : `VDO_CTRL_CODE;
   assign f.pop = is_async && pix_rise && rd_q;
   assign f.flush = !is_async || iso_rise;

   // Line-locked pixels bypass the FIFO, blanked outside active video
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         pix_ff <= '0;
      end else if (pix_rise) begin
         pix_ff <= in_active(h_cnt_ff) ? core_pixel_in : '0;
      end
   end
   assign pixel_port_bits_out = is_async ? f.rdata : pix_ff;

   // Enable is registered behind the synchroniser; the pins float three cycles after the request
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         oe_n_ff <= '1;
      end else begin
         oe_n_ff <= tri_q ? '1 : '0;
      end
   end
   assign pixel_port_oe_n_out = oe_n_ff;

   // ----------------------------------------
   // Data valid flag
   // ----------------------------------------
   always_comb begin
      nxt_dv_state = dv_state_ff;
      nxt_burst = burst_ff;
      case (dv_state_ff)
         VDO_DV_IDLE: begin
            if (mode == VDO_SIMPLE_ASYNC && f.level >= margin_ff) begin
               nxt_dv_state = VDO_DV_ON;
            end else if (mode == VDO_CTRL_ASYNC && margin_ff != '0
                  && f.level >= margin_ff) begin
               nxt_dv_state = VDO_DV_BURST;
               nxt_burst = margin_ff;
            end
         end
         VDO_DV_ON: begin
            if (mode != VDO_SIMPLE_ASYNC || f.level == '0) begin
               nxt_dv_state = VDO_DV_IDLE;
            end
         end
         VDO_DV_BURST: begin
            // Burst ends after margin words have actually left
            if (mode != VDO_CTRL_ASYNC) begin
               nxt_dv_state = VDO_DV_IDLE;
            end else if (f.pop && !f.empty) begin
               nxt_burst = burst_ff - 5'd1;
               if (burst_ff == 5'd1) begin
                  nxt_dv_state = VDO_DV_IDLE;
               end
            end
         end
         default: begin
            nxt_dv_state = VDO_DV_IDLE;
         end
      endcase
      if (mode == VDO_BASIC_ASYNC) begin
         nxt_dv_state = f.empty ? VDO_DV_IDLE : VDO_DV_ON;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         dv_state_ff <= VDO_DV_IDLE;
         burst_ff <= '0;
      end else begin
         dv_state_ff <= nxt_dv_state;
         burst_ff <= nxt_burst;
      end
   end
   assign dv_on = dv_state_ff != VDO_DV_IDLE;
   assign data_valid_flag_out = dv_on
      ^ !ctrl_ff[`VDO_CTRL_VPOL];

   // ----------------------------------------
   // Source switch and serial address
   // ----------------------------------------
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         reacq_ff <= 1'b0;
         serial_addr_out <= `VDO_ADDR_LO;
         serial_filter_en_out <= 1'b0;
      end else begin
         reacq_ff <= iso_rise;
         serial_addr_out <= address_lsb_select_q ? `VDO_ADDR_HI : `VDO_ADDR_LO;
         serial_filter_en_out <= address_lsb_select_q;
      end
   end
   assign reacquire_out = reacq_ff;

   // ----------------------------------------
   // Register port and interrupt
   // ----------------------------------------
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         ctrl_ff <= `VDO_CTRL_RST;
         margin_ff <= `VDO_MARGIN_RST;
         mask_ff <= '0;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            `VDO_REG_CTRL: ctrl_ff <= reg_wdata_in[4:0];
            `VDO_REG_MARGIN: margin_ff <= reg_wdata_in[4:0];
            `VDO_REG_MASK: mask_ff <= reg_wdata_in[2:0];
            default: ;
         endcase
      end
   end

   assign events[`VDO_ST_SWITCH] = iso_rise;
   assign events[`VDO_ST_FIELD] = pix_rise && h_last && v_last;
   assign events[`VDO_ST_OVF] = f.push && f.full;

   // Clear on read, but an event in the same cycle survives
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         status_ff <= '0;
      end else if (reg_rd_in && reg_addr_in == `VDO_REG_STATUS) begin
         status_ff <= events;
      end else begin
         status_ff <= status_ff | events;
      end
   end
   assign irq_out = |(status_ff & mask_ff);

   always_comb begin
      nxt_rdata = '0;
      case (reg_addr_in)
         `VDO_REG_CTRL: nxt_rdata[4:0] = ctrl_ff;
         `VDO_REG_MARGIN: nxt_rdata[4:0] = margin_ff;
         `VDO_REG_STATUS: nxt_rdata[2:0] = status_ff;
         `VDO_REG_MASK: nxt_rdata[2:0] = mask_ff;
         `VDO_REG_INFO: begin
            nxt_rdata[7:0] = serial_addr_out;
            nxt_rdata[`VDO_INFO_FILTER] = serial_filter_en_out;
            nxt_rdata[`VDO_INFO_EVEN] = field_even_ff;
            nxt_rdata[`VDO_INFO_LEVEL_LSB +: 5] = f.level;
         end
         default: nxt_rdata = '0;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= '0;
      end else begin
         reg_rdata_out <= reg_rd_in ? nxt_rdata : '0;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   // Reference length; lines cut short by reset or a mode change are skipped
   logic [9:0] horizontal_reference_len_ff;
   logic horizontal_reference_full_ff;
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in || is_async) begin
         horizontal_reference_len_ff <= '0;
         horizontal_reference_full_ff <= 1'b0;
      end else if ((pix_rise || iso_rise) && nxt_h_cnt == '0) begin
         horizontal_reference_len_ff <= '0;
         horizontal_reference_full_ff <= 1'b1;
      end else if (pix_rise && h_act_ff) begin
         horizontal_reference_len_ff <= horizontal_reference_len_ff + 10'd1;
      end
   end

   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);

   AST_SWITCH_RESTART: assert property (
      iso_rise |=> h_cnt_ff == '0 && v_cnt_ff == '0 && reacquire_out)
      else $error("timing not restarted after source switch");
   AST_SWITCH_ONCE: assert property (
      iso_rise |=> !iso_rise ##1 !reacquire_out)
      else $error("source switch restarted twice");
   AST_ADDR_SEL: assert property (
      ##1 serial_addr_out == ($past(address_lsb_select_q) ? 8'h8a : 8'h88)
      && serial_filter_en_out == $past(address_lsb_select_q))
      else $error("serial address does not follow select");
   AST_RESET_STATE: assert property (
      @(posedge mclk_in) disable iff (1'b0) !rst_n_in |=> h_cnt_ff == '0
      && status_ff == '0 && dv_state_ff == VDO_DV_IDLE)
      else $error("reset state not reached");
   AST_HORIZONTAL_REFERENCE_LEN: assert property (
      $fell(h_act_ff) && !is_async && $stable(mode) && horizontal_reference_full_ff
      |-> horizontal_reference_len_ff == 10'd720)
      else $error("line-locked reference not 720 samples");
   AST_HORIZONTAL_RESET_PULSE_ONE: assert property (
      is_async && h_act_ff && pix_rise && !iso_rise |=> !h_act_ff)
      else $error("horizontal reset wider than one pixel");
   AST_VERTICAL_RESET_PULSE_AFTER: assert property (
      is_async && $rose(v_act_ff) |-> $fell(h_act_ff) && !v_timing_out)
      else $error("vertical reset not after horizontal reset");
   AST_DV_EMPTY: assert property (
      mode == VDO_SIMPLE_ASYNC && $stable(mode) && $fell(dv_on)
      |-> $past(f.level) == '0)
      else $error("valid dropped before FIFO empty");
   AST_DV_BURST: assert property (
      mode == VDO_CTRL_ASYNC && $stable(mode) && $rose(dv_on)
      |-> $past(f.level) >= margin_ff && burst_ff == margin_ff)
      else $error("burst started below margin");
   AST_DV_BASIC: assert property (
      mode == VDO_BASIC_ASYNC |=> dv_on == ($past(f.level) != '0))
      else $error("basic valid does not track FIFO entries");
   AST_TRISTATE: assert property (
      tri_q [*2] |-> pixel_port_oe_n_out == 20'hfffff)
      else $error("pixel port driven while tristated");

   COV_LINE_LOCKED: cover property (!is_async ##1 $fell(h_act_ff));
   COV_FIELD_ASYNC: cover property (is_async && $rose(v_act_ff));
   COV_BURST: cover property (dv_state_ff == VDO_DV_BURST
      ##1 dv_state_ff == VDO_DV_IDLE);
   COV_SWITCH: cover property (iso_rise);
endmodule

// File: design/vdo_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for pins from outside the clock's domain
module vdo_sync #(
   parameter int W = 1
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_ff;
   // ----------------------------------------
   // Two stages, only the second is read
   // ----------------------------------------
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         meta_ff <= '0;
         q_out <= '0;
      end else begin
         meta_ff <= d_in;
         q_out <= meta_ff;
      end
   end
endmodule

// File: include/vdo_fifo_if.sv
`timescale 1ns/1ps
`include "vdo_params.svh"
interface vdo_fifo_if;
   logic push;
   logic pop;
   logic flush;
   logic [`VDO_PIX_W-1:0] wdata;
   logic [`VDO_PIX_W-1:0] rdata;
   logic [`VDO_FIFO_AW:0] level;
   logic full;
   logic empty;
   modport ctl (output push, output pop, output flush, output wdata,
      input rdata, input level, input full, input empty);
   modport mem (input push, input pop, input flush, input wdata,
      output rdata, output level, output full, output empty);
endinterface

// File: include/vdo_params.svh
`ifndef VDO_PARAMS_SVH
`define VDO_PARAMS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define VDO_REG_CTRL 8'h00
`define VDO_REG_MARGIN 8'h04
`define VDO_REG_STATUS 8'h08
`define VDO_REG_MASK 8'h0c
`define VDO_REG_INFO 8'h10
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define VDO_CTRL_MODE_LSB 0
`define VDO_CTRL_SPOL 2
`define VDO_CTRL_VPOL 3
`define VDO_CTRL_FPOL 4
`define VDO_CTRL_RST 5'h1c
`define VDO_MARGIN_RST 5'h0c
`define VDO_ST_SWITCH 0
`define VDO_ST_FIELD 1
`define VDO_ST_OVF 2
`define VDO_INFO_FILTER 8
`define VDO_INFO_EVEN 9
`define VDO_INFO_LEVEL_LSB 10
// ----------------------------------------
// Addresses, codes and timing counts
// ----------------------------------------
`define VDO_ADDR_LO 8'h88
`define VDO_ADDR_HI 8'h8a
`define VDO_CTRL_CODE 20'hff000
`define VDO_H_ACTIVE 10'd720
`define VDO_H_TOTAL 10'd858
`define VDO_V_LINES 9'd262
`define VDO_FIFO_AW 4
`define VDO_PIX_W 20
`endif

// File: include/vdo_pkg.sv
package vdo_pkg;
   // Output mode select encodings
   typedef enum logic [1:0] {
      VDO_LINE_LOCKED = 2'h0,
      VDO_SIMPLE_ASYNC = 2'h1,
      VDO_CTRL_ASYNC = 2'h2,
      VDO_BASIC_ASYNC = 2'h3
   } vdo_mode_t;
   // Data valid flag states, one-hot
   typedef enum logic [2:0] {
      VDO_DV_IDLE = 3'h1,
      VDO_DV_ON = 3'h2,
      VDO_DV_BURST = 3'h4
   } vdo_dv_state_t;
endpackage

// File: testbench/tb_video_decoder_output_port.sv
`timescale 1ns/1ps
`include "vdo_params.svh"
module tb_video_decoder_output_port;
   import vdo_pkg::*;
   localparam int LINE = 730 * 8;
   localparam int FIELD = 4 * LINE;
   logic mclk_in, rst_n_in, reg_wr_in, reg_rd_in, irq_out;
   logic [7:0] reg_addr_in, serial_addr_out;
   logic [31:0] reg_wdata_in, reg_rdata_out, d;
   logic pixel_clock_in, source_switch_in, address_lsb_select_in;
   logic fifo_read_in, output_tristate_in, h_timing_out, v_timing_out;
   logic data_valid_flag_out, field_parity_out, reacquire_out;
   logic serial_filter_en_out, stall, vpol, dv_act;
   logic [19:0] core_pixel_in, pixel_port_bits_out, pixel_port_oe_n_out;
   int error_cnt, check_count, words, hc, vc;
   assign dv_act = data_valid_flag_out ~^ vpol;
   vdo_output_port #(.H_TOTAL(10'd730), .V_LINES(9'd4))
      vdo_output_port_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .irq_out(irq_out),
      .pixel_clock_in(pixel_clock_in), .core_pixel_in(core_pixel_in),
      .source_switch_in(source_switch_in),
      .address_lsb_select_in(address_lsb_select_in),
      .fifo_read_in(fifo_read_in), .output_tristate_in(output_tristate_in),
      .pixel_port_bits_out(pixel_port_bits_out),
      .pixel_port_oe_n_out(pixel_port_oe_n_out),
      .h_timing_out(h_timing_out), .v_timing_out(v_timing_out),
      .data_valid_flag_out(data_valid_flag_out),
      .field_parity_out(field_parity_out), .reacquire_out(reacquire_out),
      .serial_addr_out(serial_addr_out),
      .serial_filter_en_out(serial_filter_en_out));
   vdo_reader_model vdo_reader_model_inst (.stall_in(stall),
      .dv_active_in(dv_act), .pixel_clock_out(pixel_clock_in),
      .fifo_read_out(fifo_read_in), .words_out(words));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_in);
   endtask
   // Let the edge's updates land before outputs are looked at
   task automatic settle(input int n);
      cyc(n);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk_in);
      reg_addr_in <= a;
      reg_wdata_in <= v;
      reg_wr_in <= 1'b1;
      @(posedge mclk_in);
      reg_wr_in <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge mclk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge mclk_in);
      reg_rd_in <= 1'b0;
      #1 v = reg_rdata_out;
   endtask
   task automatic restart();
      @(posedge mclk_in);
      source_switch_in <= 1'b1;
      cyc(3);
      source_switch_in <= 1'b0;
      settle(4);
   endtask
   // Whole-line windows make the counts independent of phase
   task automatic measure(input int n);
      hc = 0;
      vc = 0;
      repeat (n) begin
         @(posedge mclk_in);
         #1;
         hc += (h_timing_out === 1'b1) ? 1 : 0;
         vc += (v_timing_out === 1'b1) ? 1 : 0;
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      rd(`VDO_REG_CTRL, d);
      chk("ctrl", 32'h1c, d);
      rd(`VDO_REG_MARGIN, d);
      chk("margin", 32'h0c, d);
      rd(8'h14, d);
      chk("unmapped", 32'h0, d);
      chk("addr_lo", 32'h88, {24'h0, serial_addr_out});
      chk("filter_off", 32'h0, {31'h0, serial_filter_en_out});
      chk("oe_rst", 32'hfffff, {12'h0, pixel_port_oe_n_out});
   endtask
   task automatic t_pins();
      address_lsb_select_in <= 1'b1;
      output_tristate_in <= 1'b0;
      settle(5);
      chk("addr_hi", 32'h8a, {24'h0, serial_addr_out});
      chk("filter_on", 32'h1, {31'h0, serial_filter_en_out});
      chk("oe_on", 32'h0, {12'h0, pixel_port_oe_n_out});
      output_tristate_in <= 1'b1;
      settle(5);
      chk("oe_off", 32'hfffff, {12'h0, pixel_port_oe_n_out});
      output_tristate_in <= 1'b0;
   endtask
   // Switch held high: exactly one restart, then the event is read back
   task automatic t_switch();
      int p;
      p = 0;
      wr(`VDO_REG_MASK, 32'h1);
      source_switch_in <= 1'b1;
      repeat (40) begin
         @(posedge mclk_in);
         #1 p += (reacquire_out === 1'b1) ? 1 : 0;
      end
      chk("reacq_once", 32'h1, p);
      chk("irq_set", 32'h1, {31'h0, irq_out});
      rd(`VDO_REG_STATUS, d);
      chk("st_switch", 32'h1, {31'h0, d[`VDO_ST_SWITCH]});
      chk("irq_clr", 32'h0, {31'h0, irq_out});
      source_switch_in <= 1'b0;
   endtask
   task automatic t_line_locked();
      wr(`VDO_REG_CTRL, 32'h1c);
      restart();
      chk("fld_odd", 32'h0, {31'h0, field_parity_out});
      measure(FIELD);
      chk("horizontal_reference_len", 4 * 720 * 8, hc);
      chk("vref", 32'd8, vc);
      settle(16);
      chk("fld_even", 32'h1, {31'h0, field_parity_out});
      wr(`VDO_REG_CTRL, 32'h18);
      measure(LINE);
      chk("horizontal_reference_inv", 32'd80, hc);
   endtask
   task automatic t_async();
      wr(`VDO_REG_CTRL, 32'h1d);
      measure(FIELD);
      chk("horizontal_reset_pulse", 32'd32, hc);
      chk("vertical_reset_pulse", FIELD - 8, vc);
   endtask
   // Reader stalled: valid thresholds, overflow, then draining
   task automatic t_valid();
      stall <= 1'b1;
      core_pixel_in <= 20'h0abcd;
      wr(`VDO_REG_MARGIN, 32'h5);
      wr(`VDO_REG_MASK, 32'h4);
      restart();
      settle(9);
      chk("dv_below", 32'h0, {31'h0, data_valid_flag_out});
      settle(80);
      chk("dv_margin", 32'h1, {31'h0, data_valid_flag_out});
      wr(`VDO_REG_CTRL, 32'h1f);
      restart();
      settle(24);
      chk("dv_any", 32'h1, {31'h0, data_valid_flag_out});
      settle(200);
      chk("irq_ovf", 32'h1, {31'h0, irq_out});
      rd(`VDO_REG_STATUS, d);
      chk("st_ovf", 32'h1, {31'h0, d[`VDO_ST_OVF]});
      vpol <= 1'b0;
      wr(`VDO_REG_CTRL, 32'h17);
      settle(2);
      chk("dv_pol", 32'h0, {31'h0, data_valid_flag_out});
      stall <= 1'b0;
      settle(200);
      chk("drained", 32'h1, {31'h0, words > 0});
      chk("pix", 32'h1, {31'h0, pixel_port_bits_out === 20'h0abcd ||
          pixel_port_bits_out === 20'hff000});
   endtask
   // Controlled mode: a burst stays open until the reader takes it
   task automatic t_burst();
      int lo;
      stall <= 1'b1;
      vpol <= 1'b1;
      wr(`VDO_REG_CTRL, 32'h1e);
      restart();
      settle(80);
      chk("burst_on", 32'h1, {31'h0, data_valid_flag_out});
      lo = 0;
      stall <= 1'b0;
      repeat (120) begin
         @(posedge mclk_in);
         #1 lo += (data_valid_flag_out === 1'b0) ? 1 : 0;
      end
      chk("burst_end", 32'h1, {31'h0, lo > 0});
   endtask
   // ----------------------------------------
   // Verdict, clock, watchdog and main run
   // ----------------------------------------
   task automatic conclude();
      $display("Checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      mclk_in = 1'b0;
      forever #20 mclk_in = ~mclk_in;
   end
   // Expected run is near 53k cycles; leave margin for slow settling
   initial begin
      repeat (80000) @(posedge mclk_in);
      error_cnt++;
      conclude();
   end
   initial begin
      error_cnt = 0;
      check_count = 0;
      rst_n_in = 1'b0;
      reg_addr_in = 8'h0;
      reg_wdata_in = 32'h0;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      core_pixel_in = 20'h0;
      source_switch_in = 1'b0;
      address_lsb_select_in = 1'b0;
      output_tristate_in = 1'b1;
      stall = 1'b0;
      vpol = 1'b1;
      cyc(2);
      rst_n_in <= 1'b1;
      cyc(4);
      t_reset();
      t_pins();
      t_switch();
      t_line_locked();
      t_async();
      t_valid();
      t_burst();
      conclude();
   end
endmodule

// File: testbench/vdo_reader_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Capture side: pixel clock and FIFO reader
// ----------------------------------------
module vdo_reader_model (
   input wire logic stall_in,
   input wire logic dv_active_in,
   output logic pixel_clock_out,
   output logic fifo_read_out,
   output int words_out
);
   // Pixel clock 320 ns, phase offset from the system clock on purpose
   initial begin
      pixel_clock_out = 1'b0;
      #7;
      forever #160 pixel_clock_out = ~pixel_clock_out;
   end
   // Read enable moves on the falling pixel edge, away from sampling
   initial fifo_read_out = 1'b0;
   always @(negedge pixel_clock_out) begin
      fifo_read_out <= dv_active_in && !stall_in;
   end
   // Words taken: one per pixel rise while read is high
   initial words_out = 0;
   always @(posedge pixel_clock_out) begin
      if (fifo_read_out)
         words_out <= words_out + 1;
   end
endmodule
